// >>> design/mrc_input_decode.sv
// mrc_input_decode: maps assignable terminals to internal command levels
`timescale 1ns/1ns
module mrc_input_decode (
  // clock and reset
  input  wire logic                                clk_i,
  input  wire logic                                srst_i,
  // raw terminals and their function settings
  input  wire logic [mrc_pkg::MRC_NUM_IN-1:0]      term_i,
  input  wire logic [mrc_pkg::MRC_NUM_IN*12-1:0]   func_i,
  // decoded terminal commands
  output logic                                     fwd_o,
  output logic                                     rev_o,
  output logic                                     hold_o,
  output logic                                     hold_assigned_o,
  output logic                                     linken_o,
  output logic                                     gen_o,
  output logic                                     term_o,
  output logic                                     orgrp_o,
  output logic                                     igngrp_o
);
  import mrc_pkg::*;
  logic [MRC_NUM_IN-1:0] sync1_reg;
  logic [MRC_NUM_IN-1:0] sync2_reg;
  logic [MRC_NUM_IN-1:0] sync_next;
  logic [8:0]            cmd_reg;
  logic [8:0]            cmd_next;

  // strip the negative-logic offset from a setting
  function automatic logic [11:0] base_fn(input logic [11:0] f);
    base_fn = (f >= MRC_NEG_OFFSET) ? f - MRC_NEG_OFFSET : f;
  endfunction

  // ==========================================================
  // two-stage synchroniser
  always_comb begin
    sync_next = term_i;
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= sync_next;
      sync2_reg <= sync1_reg;
    end
  end

  // ==========================================================
  // decode and OR all terminals that carry each function
  always_comb begin
    logic [11:0] f;
    logic [11:0] b;
    logic        lvl;
    f = '0;
    b = '0;
    lvl = 1'b0;
    cmd_next = '0;
    for (int i = 0; i < MRC_NUM_IN; i++) begin
      f = func_i[i*12 +: 12];
      b = base_fn(f);
      lvl = sync2_reg[i] ^ (f >= MRC_NEG_OFFSET);
      if (b == MRC_FN_FWD) cmd_next[0] = cmd_next[0] | sync2_reg[i];
      if (b == MRC_FN_REV) cmd_next[1] = cmd_next[1] | sync2_reg[i];
      if (b == MRC_FN_HOLD) begin
        cmd_next[2] = cmd_next[2] | lvl;
        cmd_next[3] = 1'b1;
      end
      if (b == MRC_FN_LINKEN) cmd_next[4] = cmd_next[4] | lvl;
      if (b == MRC_FN_GEN)    cmd_next[5] = cmd_next[5] | lvl;
      if (b == MRC_FN_TERM)   cmd_next[6] = cmd_next[6] | lvl;
      if (b == MRC_FN_ORGRP)  cmd_next[7] = cmd_next[7] | lvl;
      if (b == MRC_FN_IGNGRP) cmd_next[8] = cmd_next[8] | lvl;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cmd_reg <= '0;
    end else begin
      cmd_reg <= cmd_next;
    end
  end

  assign fwd_o           = cmd_reg[0];
  assign rev_o           = cmd_reg[1];
  assign hold_o          = cmd_reg[2];
  assign hold_assigned_o = cmd_reg[3];
  assign linken_o        = cmd_reg[4];
  assign gen_o           = cmd_reg[5];
  assign term_o          = cmd_reg[6];
  assign orgrp_o         = cmd_reg[7];
  assign igngrp_o        = cmd_reg[8];
endmodule

// >>> design/mrc_pkg.sv
// mrc_pkg: shared constants and types for the motor run-command logic
package mrc_pkg;
  // ==========================================================
  // input function assignment codes
  localparam logic [11:0] MRC_FN_NONE    = 12'h0ff;
  localparam logic [11:0] MRC_FN_FWD     = 12'h062;
  localparam logic [11:0] MRC_FN_REV     = 12'h063;
  localparam logic [11:0] MRC_FN_HOLD    = 12'h006;
  localparam logic [11:0] MRC_FN_LINKEN  = 12'h018;
  localparam logic [11:0] MRC_FN_GEN     = 12'h00b;
  localparam logic [11:0] MRC_FN_TERM    = 12'h00c;
  localparam logic [11:0] MRC_FN_ORGRP   = 12'h00d;
  localparam logic [11:0] MRC_FN_IGNGRP  = 12'h00e;
  localparam logic [11:0] MRC_NEG_OFFSET = 12'h3e8;
  // ==========================================================
  // link operation word bit positions
  localparam int MRC_LW_FWD   = 0;
  localparam int MRC_LW_REV   = 1;
  localparam int MRC_LW_GEN   = 2;
  localparam int MRC_LW_ORGRP = 3;
  localparam int MRC_LW_IGN   = 4;
  localparam int MRC_LW_B13   = 13;
  localparam int MRC_LW_B14   = 14;
  // ==========================================================
  // settings
  localparam logic [1:0] MRC_SRC_KEYPAD = 2'h0;
  localparam logic [1:0] MRC_STOPPRI_A  = 2'h1;
  localparam logic [1:0] MRC_STOPPRI_B  = 2'h3;
  localparam int MRC_FREQ_W  = 16;
  localparam int MRC_TIMER_W = 16;
  localparam int MRC_NUM_IN  = 5;
  typedef enum logic [1:0] {
    MRC_DIR_STOP,
    MRC_DIR_FWD,
    MRC_DIR_REV
  } mrc_dir_t;
endpackage

// >>> design/mrc_run_cmd.sv
// mrc_run_cmd: top of the motor run-command logic
`timescale 1ns/1ns
module mrc_run_cmd (
  // clock and reset
  input  wire logic                                  clk_i,
  input  wire logic                                  srst_i,
  // terminal block: programmable inputs 1..3, forward, reverse
  input  wire logic [mrc_pkg::MRC_NUM_IN-1:0]        term_i,
  input  wire logic [mrc_pkg::MRC_NUM_IN*12-1:0]     term_func_i,
  // keypad
  input  wire logic                                  key_run_i,
  input  wire logic                                  key_stop_i,
  input  wire logic                                  jog_i,
  // serial link
  input  wire logic [15:0]                           link_operation_word_i,
  // settings
  input  wire logic [1:0]                            run_source_select_i,
  input  wire logic [1:0]                            stop_key_priority_sel_i,
  input  wire logic [11:0]                           fwd_terminal_function_i,
  input  wire logic [11:0]                           rev_terminal_function_i,
  input  wire logic                                  timer_en_i,
  input  wire logic [mrc_pkg::MRC_TIMER_W-1:0]       timer_preset_i,
  // frequencies
  input  wire logic [mrc_pkg::MRC_FREQ_W-1:0]        set_freq_i,
  input  wire logic [mrc_pkg::MRC_FREQ_W-1:0]        start_frequency_i,
  input  wire logic [mrc_pkg::MRC_FREQ_W-1:0]        stop_frequency_i,
  // internal run commands and drive frequency
  output logic                                       int_fwd_o,
  output logic                                       int_rev_o,
  output logic signed [mrc_pkg::MRC_FREQ_W:0]        drive_freq_o,
  // decoded command outputs
  output logic                                       link_enable_cmd_o,
  output logic                                       gen_cmd_o,
  output logic                                       term_cmd_o,
  output logic                                       or_cmd_o,
  output logic                                       ign_cmd_o,
  output logic                                       run_hold_o
);
  import mrc_pkg::*;

  // ==========================================================
  // synchronisers for keypad and link inputs
  logic [18:0] ksync1_reg;
  logic [18:0] ksync2_reg;
  logic [18:0] ksync_next;
  logic        key_run_s;
  logic        key_stop_s;
  logic        jog_s;
  logic [15:0] lw_s;

  always_comb begin
    ksync_next = {jog_i, key_run_i, key_stop_i, link_operation_word_i};
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ksync1_reg <= '0;
      ksync2_reg <= '0;
    end else begin
      ksync1_reg <= ksync_next;
      ksync2_reg <= ksync1_reg;
    end
  end

  assign key_run_s  = ksync2_reg[17];
  assign key_stop_s = ksync2_reg[16];
  assign jog_s      = ksync2_reg[18];
  assign lw_s       = ksync2_reg[15:0];

  // ==========================================================
  // terminal decoding
  logic t_fwd;
  logic t_rev;
  logic t_hold;
  logic hold_asg;
  logic t_linken;
  logic t_gen;
  logic t_term;
  logic t_or;
  logic t_ign;
  mrc_input_decode u_dec (
    .clk_i           (clk_i),
    .srst_i          (srst_i),
    .term_i          (term_i),
    .func_i          (term_func_i),
    .fwd_o           (t_fwd),
    .rev_o           (t_rev),
    .hold_o          (t_hold),
    .hold_assigned_o (hold_asg),
    .linken_o        (t_linken),
    .gen_o           (t_gen),
    .term_o          (t_term),
    .orgrp_o         (t_or),
    .igngrp_o        (t_ign)
  );

  // ==========================================================
  // link word processing
  logic link_en;
  logic fwd_cmd;
  logic rev_cmd;
  logic b13_fwd;
  logic b14_fwd;
  logic b13_rev;
  logic b14_rev;
  // true when a programmable link bit acts as the given run command
  function automatic logic bit_is(input logic [11:0] setting, input logic [11:0] fn);
    bit_is = (setting == fn);
  endfunction
  always_comb begin
    b13_fwd = bit_is(fwd_terminal_function_i, MRC_FN_FWD) & lw_s[MRC_LW_B13];
    b14_fwd = bit_is(rev_terminal_function_i, MRC_FN_FWD) & lw_s[MRC_LW_B14];
    b13_rev = bit_is(fwd_terminal_function_i, MRC_FN_REV) & lw_s[MRC_LW_B13];
    b14_rev = bit_is(rev_terminal_function_i, MRC_FN_REV) & lw_s[MRC_LW_B14];
    // tie: both bits carry the same command; the pair acts as an OR
    link_en = lw_s[MRC_LW_B13] | lw_s[MRC_LW_B14] | t_linken;
    if (link_en) begin
      fwd_cmd = lw_s[MRC_LW_FWD] | b13_fwd | b14_fwd;
      rev_cmd = lw_s[MRC_LW_REV] | b13_rev | b14_rev;
    end else begin
      fwd_cmd = t_fwd;
      rev_cmd = t_rev;
    end
  end

  // ==========================================================
  // decoded command groups
  logic [4:0] grp_reg;
  logic [4:0] grp_next;

  always_comb begin
    grp_next[0] = link_en;
    grp_next[1] = link_en ? lw_s[MRC_LW_GEN] : t_gen;
    grp_next[2] = t_term;
    grp_next[3] = lw_s[MRC_LW_ORGRP] | t_or;
    grp_next[4] = t_ign;
  end
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      grp_reg <= '0;
    end else begin
      grp_reg <= grp_next;
    end
  end
  assign link_enable_cmd_o = grp_reg[0];
  assign gen_cmd_o         = grp_reg[1];
  assign term_cmd_o        = grp_reg[2];
  assign or_cmd_o          = grp_reg[3];
  assign ign_cmd_o         = grp_reg[4];

  // ==========================================================
  // keypad latch, hold latch and run decision
  logic     kp_run_reg;
  logic     kp_run_next;
  logic     hold_fwd_reg;
  logic     hold_fwd_next;
  logic     hold_rev_reg;
  logic     hold_rev_next;
  logic     khold_reg;
  logic     khold_next;
  mrc_dir_t dir_reg;
  mrc_dir_t dir_next;
  logic     tmr_exp;
  logic     stop_pri;
  logic     eff_fwd;
  logic     eff_rev;
  logic     run_req;
  assign stop_pri = (stop_key_priority_sel_i == MRC_STOPPRI_A) ||
                    (stop_key_priority_sel_i == MRC_STOPPRI_B);
  always_comb begin
    kp_run_next   = kp_run_reg;
    hold_fwd_next = hold_fwd_reg;
    hold_rev_next = hold_rev_reg;
    khold_next    = khold_reg;
    if (key_run_s) begin
      kp_run_next = 1'b1;
      khold_next  = 1'b1;
    end
    if (key_stop_s && !jog_s) begin
      kp_run_next = 1'b0;
      khold_next  = 1'b0;
    end
    if (hold_asg) begin
      // three-wire: latch on momentary run, release when hold drops
      hold_fwd_next = t_hold & (hold_fwd_reg | fwd_cmd);
      hold_rev_next = t_hold & (hold_rev_reg | rev_cmd);
    end else begin
      hold_fwd_next = 1'b0;
      hold_rev_next = 1'b0;
    end
    if (tmr_exp) begin
      kp_run_next = 1'b0;
      khold_next  = 1'b0;
    end
  end

  always_comb begin
    eff_fwd = hold_asg ? (fwd_cmd | hold_fwd_reg) : fwd_cmd;
    eff_rev = hold_asg ? (rev_cmd | hold_rev_reg) : rev_cmd;
    if (run_source_select_i == MRC_SRC_KEYPAD) begin
      eff_fwd = eff_fwd & kp_run_reg;
      eff_rev = eff_rev & kp_run_reg;
    end
    run_req  = eff_fwd | eff_rev;
    dir_next = MRC_DIR_STOP;
    if (eff_fwd && eff_rev) begin
      dir_next = MRC_DIR_STOP;
    end else if (stop_pri && key_stop_s) begin
      dir_next = MRC_DIR_STOP;
    end else if (tmr_exp) begin
      dir_next = MRC_DIR_STOP;
    end else if (set_freq_i < start_frequency_i || set_freq_i < stop_frequency_i) begin
      dir_next = MRC_DIR_STOP;
    end else if (eff_fwd) begin
      dir_next = MRC_DIR_FWD;
    end else if (eff_rev) begin
      dir_next = MRC_DIR_REV;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      kp_run_reg   <= 1'b0;
      hold_fwd_reg <= 1'b0;
      hold_rev_reg <= 1'b0;
      khold_reg    <= 1'b0;
      dir_reg      <= MRC_DIR_STOP;
    end else begin
      kp_run_reg   <= kp_run_next;
      hold_fwd_reg <= hold_fwd_next;
      hold_rev_reg <= hold_rev_next;
      khold_reg    <= khold_next;
      dir_reg      <= dir_next;
    end
  end
  mrc_run_timer u_tmr (
    .clk_i     (clk_i),
    .srst_i    (srst_i),
    .enable_i  (timer_en_i),
    .start_i   (run_req),
    .running_i (run_req),
    .preset_i  (timer_preset_i),
    .expired_o (tmr_exp)
  );

  assign int_fwd_o  = (dir_reg == MRC_DIR_FWD);
  assign int_rev_o  = (dir_reg == MRC_DIR_REV);
  assign run_hold_o = (hold_fwd_reg | hold_rev_reg | khold_reg) & ~tmr_exp;

  // ==========================================================
  // drive frequency command
  logic signed [MRC_FREQ_W:0] dfreq_reg;
  logic signed [MRC_FREQ_W:0] dfreq_next;
  always_comb begin
    dfreq_next = '0;
    if (dir_reg == MRC_DIR_FWD) begin
      dfreq_next = signed'({1'b0, set_freq_i});
    end else if (dir_reg == MRC_DIR_REV) begin
      dfreq_next = -signed'({1'b0, set_freq_i});
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      dfreq_reg <= '0;
    end else begin
      dfreq_reg <= dfreq_next;
    end
  end

  assign drive_freq_o = dfreq_reg;

  // ==========================================================
  // checks
  property p_interlock;
    @(posedge clk_i) disable iff (srst_i)
      (eff_fwd && eff_rev) |=> !int_fwd_o && !int_rev_o;
  endproperty
  a_interlock: assert property (p_interlock) else $error("fwd and rev both on");
  property p_stop_pri;
    @(posedge clk_i) disable iff (srst_i)
      (stop_pri && key_stop_s) |=> !int_fwd_o && !int_rev_o;
  endproperty
  a_stop_pri: assert property (p_stop_pri) else $error("stop key ignored");
  property p_low_freq;
    @(posedge clk_i) disable iff (srst_i)
      (set_freq_i < start_frequency_i || set_freq_i < stop_frequency_i)
        |=> !int_fwd_o && !int_rev_o;
  endproperty
  a_low_freq: assert property (p_low_freq) else $error("run below start or stop frequency");
  property p_link_en;
    @(posedge clk_i) disable iff (srst_i)
      (lw_s[MRC_LW_B13] || lw_s[MRC_LW_B14]) |=> link_enable_cmd_o;
  endproperty
  a_link_en: assert property (p_link_en) else $error("link enable missing");
  property p_rev_neg;
    @(posedge clk_i) disable iff (srst_i)
      int_rev_o |=> drive_freq_o == -$signed({1'b0, $past(set_freq_i)});
  endproperty
  a_rev_neg: assert property (p_rev_neg) else $error("reverse frequency not negated");
  property p_stop_zero;
    @(posedge clk_i) disable iff (srst_i)
      (!int_fwd_o && !int_rev_o) |=> drive_freq_o == 0;
  endproperty
  a_stop_zero: assert property (p_stop_zero) else $error("stopped frequency not zero");
  property p_kp_src;
    @(posedge clk_i) disable iff (srst_i)
      (run_source_select_i == MRC_SRC_KEYPAD && !kp_run_reg) |=> !int_fwd_o && !int_rev_o;
  endproperty
  a_kp_src: assert property (p_kp_src) else $error("run without keypad run");
  property p_ign;
    @(posedge clk_i) disable iff (srst_i)
      (lw_s[MRC_LW_IGN] && !t_ign) |=> !ign_cmd_o;
  endproperty
  a_ign: assert property (p_ign) else $error("ignore group follows link");
endmodule

// >>> design/mrc_run_timer.sv
// mrc_run_timer: run timer that reports expiry of the preset time
`timescale 1ns/1ns
module mrc_run_timer (
  // clock and reset
  input  wire logic                              clk_i,
  input  wire logic                              srst_i,
  // control
  input  wire logic                              enable_i,
  input  wire logic                              start_i,
  input  wire logic                              running_i,
  input  wire logic [mrc_pkg::MRC_TIMER_W-1:0]   preset_i,
  // status
  output logic                                   expired_o
);
  import mrc_pkg::*;
  logic [MRC_TIMER_W-1:0] cnt_reg;
  logic [MRC_TIMER_W-1:0] cnt_next;
  logic                   act_reg;
  logic                   act_next;
  logic                   exp_reg;
  logic                   exp_next;

  always_comb begin
    cnt_next = cnt_reg;
    act_next = act_reg;
    // expiry holds until the run request drops or the timer is disabled, so a held run cannot restart
    exp_next = exp_reg & enable_i & running_i;
    if (!enable_i || !running_i) begin
      act_next = 1'b0;
      cnt_next = '0;
    end else if (start_i && !act_reg && !exp_reg) begin
      act_next = 1'b1;
      cnt_next = '0;
    end else if (act_reg) begin
      if (cnt_reg >= preset_i) begin
        exp_next = 1'b1;
        act_next = 1'b0;
      end else begin
        cnt_next = cnt_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cnt_reg <= '0;
      act_reg <= 1'b0;
      exp_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      act_reg <= act_next;
      exp_reg <= exp_next;
    end
  end

  assign expired_o = exp_reg;
endmodule

// >>> verif/mrc_partner.sv
// mrc_partner: terminal block, keypad and link host facing the run-command logic
`timescale 1ns/1ns
module mrc_partner (
  // clock
  input  wire logic        clk_i,
  // levels requested by the bench
  input  wire logic [4:0]  term_req_i,
  input  wire logic [2:0]  key_req_i,
  input  wire logic [15:0] word_req_i,
  // levels seen by the block
  output logic [4:0]       term_o,
  output logic [2:0]       key_o,
  output logic [15:0]      word_o
);
  // ==========================================
  // pins change just after an edge, then stand
  always @(posedge clk_i) begin
    term_o <= term_req_i;
    key_o  <= key_req_i;
    word_o <= word_req_i;
  end
endmodule

// >>> verif/tb_mrc_run_cmd.sv
// tb_mrc_run_cmd: self-checking bench for the motor run-command logic
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("mismatch %s expected %0h seen %0h", nm, e, g); end end
module tb_mrc_run_cmd;
  import mrc_pkg::*;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [4:0] term_r = '0;
  logic [2:0] key_r = '0;
  logic [15:0] word_r = '0;
  logic [4:0] term_w;
  logic [2:0] key_w;
  logic [15:0] word_w;
  logic [11:0] fn [5] = '{default: MRC_FN_NONE};
  logic [11:0] base [5] = '{MRC_FN_GEN, MRC_FN_ORGRP, MRC_FN_IGNGRP, MRC_FN_TERM, MRC_FN_LINKEN};
  logic [11:0] lf [5] = '{MRC_FN_NONE, MRC_FN_NONE, MRC_FN_FWD, MRC_FN_NONE, MRC_FN_FWD};
  logic [11:0] lr [5] = '{MRC_FN_NONE, MRC_FN_NONE, MRC_FN_NONE, MRC_FN_REV, MRC_FN_FWD};
  logic [15:0] lw [5] = '{16'h2001, 16'h2002, 16'h2000, 16'h4000, 16'h4000};
  logic [1:0] src = 2'h1;
  logic [1:0] pri = 2'h0;
  logic [11:0] fwd_fn = MRC_FN_NONE;
  logic [11:0] rev_fn = MRC_FN_NONE;
  logic tmr_en = 1'b0;
  logic [15:0] preset = 16'h0014;
  logic [15:0] sf = 16'h0100;
  logic [15:0] stf = 16'h0010;
  logic [15:0] spf = 16'h0010;
  logic int_fwd, int_rev, lnk_en, gen, tc, orc, ign, hold;
  logic signed [16:0] dfreq;
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [31:0] rs = 32'hd8a7fdfc;

  always #25 clk_i = ~clk_i;

  mrc_partner u_far (
    .clk_i(clk_i), .term_req_i(term_r), .key_req_i(key_r), .word_req_i(word_r),
    .term_o(term_w), .key_o(key_w), .word_o(word_w));

  mrc_run_cmd dut (
    .clk_i(clk_i), .srst_i(srst_i), .term_i(term_w),
    .term_func_i({fn[4], fn[3], fn[2], fn[1], fn[0]}),
    .key_run_i(key_w[0]), .key_stop_i(key_w[1]), .jog_i(key_w[2]),
    .link_operation_word_i(word_w), .run_source_select_i(src),
    .stop_key_priority_sel_i(pri), .fwd_terminal_function_i(fwd_fn),
    .rev_terminal_function_i(rev_fn), .timer_en_i(tmr_en), .timer_preset_i(preset),
    .set_freq_i(sf), .start_frequency_i(stf), .stop_frequency_i(spf),
    .int_fwd_o(int_fwd), .int_rev_o(int_rev), .drive_freq_o(dfreq),
    .link_enable_cmd_o(lnk_en), .gen_cmd_o(gen), .term_cmd_o(tc), .or_cmd_o(orc),
    .ign_cmd_o(ign), .run_hold_o(hold));

  // ==========================================
  // helpers
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 8000) begin
      error_cnt++;
      print_verdict();
    end
  end

  function automatic logic [31:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction

  // levels settle well within the eight edges waited here
  task automatic go(input logic [4:0] t, input logic [2:0] k, input logic [15:0] w);
    @(posedge clk_i);
    term_r <= t;
    key_r  <= k;
    word_r <= w;
    repeat (8) @(posedge clk_i);
    #1;
  endtask

  function automatic logic [1:0] run_model(input logic f, r, kp, stop);
    logic [1:0] v;
    v = {r, f};
    if (src == MRC_SRC_KEYPAD && !kp) v = 2'b00;
    if (f && r) v = 2'b00;
    if ((pri == MRC_STOPPRI_A || pri == MRC_STOPPRI_B) && stop) v = 2'b00;
    if (sf < stf || sf < spf) v = 2'b00;
    return v;
  endfunction

  task automatic chk_run(input logic [1:0] e);
    logic signed [16:0] x;
    x = e[0] ? $signed({1'b0, sf}) : (e[1] ? -$signed({1'b0, sf}) : 17'sh0);
    `CHK("int_fwd", e[0], int_fwd)
    `CHK("int_rev", e[1], int_rev)
    `CHK("drive_freq", x, dfreq)
  endtask

  // ==========================================
  // main sequence
  initial begin
    logic [31:0] v;
    logic [4:0] lv;
    logic [2:0] ks [7];
    logic kp [7];
    logic e;
    ks = '{3'h0, 3'h1, 3'h0, 3'h6, 3'h0, 3'h2, 3'h0};
    kp = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
    repeat (16) @(posedge clk_i);
    #1;
    chk_run(2'b00);
    @(posedge clk_i);
    srst_i <= 1'b0;
    fn[3] <= MRC_FN_FWD;
    fn[4] <= MRC_FN_REV;
    for (int p = 0; p < 4; p++) begin
      for (int k = 0; k < 8; k++) begin
        pri <= 2'(p);
        go({k[1:0], 3'b000}, {1'b0, k[2], 1'b0}, '0);
        chk_run(run_model(k[0], k[1], 1'b0, k[2]));
      end
    end
    fn[3] <= MRC_FN_FWD + MRC_NEG_OFFSET;
    go(5'b01000, 3'b000, '0);
    chk_run(2'b01);
    go(5'b00000, 3'b000, '0);
    chk_run(2'b00);
    fn[3] <= MRC_FN_FWD;
    $display("test two_wire done");
    pri <= 2'h0;
    for (int i = 0; i < 3; i++) begin
      sf  <= (i == 0) ? 16'h0008 : ((i == 1) ? 16'h0010 : 16'h0018);
      spf <= (i == 2) ? 16'h0020 : 16'h0010;
      go(5'b01000, 3'b000, '0);
      chk_run(run_model(1'b1, 1'b0, 1'b0, 1'b0));
    end
    sf  <= 16'h0100;
    spf <= 16'h0010;
    $display("test freq_gate done");
    fn[0] <= MRC_FN_HOLD;
    go(5'b01001, 3'b000, '0);
    `CHK("run_hold", 1'b1, hold)
    go(5'b00001, 3'b000, '0);
    chk_run(2'b01);
    go(5'b00000, 3'b000, '0);
    chk_run(2'b00);
    $display("test three_wire done");
    fn[0] <= MRC_FN_NONE;
    src <= MRC_SRC_KEYPAD;
    for (int i = 0; i < 7; i++) begin
      go(5'b01000, ks[i], '0);
      chk_run(run_model(1'b1, 1'b0, kp[i], 1'b0));
    end
    src <= 2'h1;
    $display("test keypad done");
    for (int i = 0; i < 5; i++) begin
      fwd_fn <= lf[i];
      rev_fn <= lr[i];
      go('0, 3'b000, lw[i]);
      chk_run((i == 1 || i == 3) ? 2'b10 : 2'b01);
    end
    fwd_fn <= MRC_FN_NONE;
    rev_fn <= MRC_FN_NONE;
    $display("test link_run done");
    tmr_en <= 1'b1;
    go(5'b01000, 3'b000, '0);
    chk_run(2'b01);
    for (int n = 0; n < 40 && int_fwd === 1'b1; n++) begin
      @(posedge clk_i);
      #1;
    end
    `CHK("timer_clear", 1'b0, int_fwd)
    repeat (4) @(posedge clk_i);
    #1;
    `CHK("timer_hold", 1'b0, int_fwd)
    tmr_en <= 1'b0;
    go('0, 3'b000, '0);
    $display("test timer done");
    for (int i = 0; i < 24; i++) begin
      v = xs();
      for (int j = 0; j < 5; j++) fn[j] <= base[j] + (v[8+j] ? MRC_NEG_OFFSET : 12'h0);
      go(v[4:0], 3'b000, {1'b0, v[14:13], 8'h00, v[18:16], 2'b00});
      lv = v[4:0] ^ v[12:8];
      e = v[13] | v[14] | lv[4];
      `CHK("link_enable", e, lnk_en)
      `CHK("gen_cmd", e ? v[16] : lv[0], gen)
      `CHK("or_cmd", v[17] | lv[1], orc)
      `CHK("ign_cmd", lv[2], ign)
      `CHK("term_cmd", lv[3], tc)
    end
    $display("test decoders done");
    print_verdict();
  end
endmodule
